// file: core/teaching_pio_handshake.sv
// Teaching-pattern PIO handshake with AXI4-Lite control and status
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module teaching_pio_handshake import teaching_pio_pkg::*; #(
  parameter int MS_TICK_CYCLES = MS_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire pio_in_s pioIn,
  output pio_out_s pioOut,
  output motion_cmd_s motionCmd,
  input wire motion_sts_s motionSts,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int MSW = $clog2(MS_TICK_CYCLES + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_TICK_CYCLES - 1);
  localparam int IN_W = $bits(pio_in_s);

  typedef enum {ST_IDLE, ST_MOVE, ST_JOG, ST_HOME} motion_e;
  typedef enum {STO_IDLE, STO_HOLD, STO_WAIT, STO_DONE} store_e;

  function automatic reg_sel_e decodeReg(input logic [AXI_ADDR_W-1:0] a);
    if (a == OFS_CTRL) begin
      return REG_CTRL;
    end else if (a == OFS_STATUS) begin
      return REG_STATUS;
    end else if (a == OFS_INPUTS) begin
      return REG_INPUTS;
    end else if (a == OFS_POSITION) begin
      return REG_POSITION;
    end else begin
      return REG_NONE;
    end
  endfunction : decodeReg

  // ----------------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------------
  pio_in_s meta_q;
  pio_in_s sync_q;
  pio_in_s prev_q;
  pio_in_s rise;
  logic [31:0] ctrl_q;
  logic pioEnable;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else if (clkEn) begin
      meta_q <= pioIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;
  assign pioEnable = ctrl_q[CTRL_EN_BIT];

  logic teachMode;
  logic faultFree;
  logic canMove;
  logic startEdge;
  logic jogPlusEdge;
  logic jogMinusEdge;
  logic homeEdge;
  logic clearEdge;
  logic alarmActive_q;
  logic estopActive_q;

  assign teachMode = sync_q.teachSelect;
  assign faultFree = !alarmActive_q && !estopActive_q;
  assign canMove = sync_q.servoEnable && faultFree && motionSts.driveReady;
  assign startEdge = pioEnable && rise.moveStart && canMove;
  assign jogPlusEdge = pioEnable && rise.jogPlusReq && canMove;
  assign jogMinusEdge = pioEnable && rise.jogMinusReq && canMove;
  assign homeEdge = pioEnable && rise.originSearchReq && canMove;
  assign clearEdge = pioEnable && rise.alarmClear;

  // ----------------------------------------------------------------------
  // Motion sequencing
  // ----------------------------------------------------------------------
  motion_e mstate_q;
  logic [POS_W-1:0] target_q;
  logic jogInch_q;
  logic jogDirPlus_q;
  logic zoneArmed_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mstate_q <= ST_IDLE;
      target_q <= '0;
      jogInch_q <= 1'b0;
      jogDirPlus_q <= 1'b0;
    end else if (clkEn) begin
      case (mstate_q)
        ST_IDLE: begin
          if (startEdge) begin
            mstate_q <= ST_MOVE;
            target_q <= sync_q.posSel;
          end else if (homeEdge) begin
            mstate_q <= ST_HOME;
          end else if (jogPlusEdge || jogMinusEdge) begin
            mstate_q <= ST_JOG;
            jogInch_q <= sync_q.stepStyleSelect;
            jogDirPlus_q <= jogPlusEdge;
          end
        end
        ST_MOVE: begin
          if (!canMove || motionSts.targetReached) begin
            mstate_q <= ST_IDLE;
          end
        end
        ST_JOG: begin
          if (!canMove || (jogInch_q && !motionSts.moving)
              || (!jogInch_q && !(jogDirPlus_q ? sync_q.jogPlusReq
                                              : sync_q.jogMinusReq))) begin
            mstate_q <= ST_IDLE;
          end
        end
        ST_HOME: begin
          if (!canMove || motionSts.homeDone) begin
            mstate_q <= ST_IDLE;
          end
        end
        default: begin
          mstate_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      zoneArmed_q <= 1'b0;
    end else if (clkEn && startEdge && mstate_q == ST_IDLE) begin
      zoneArmed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Position store with millisecond time base
  // ----------------------------------------------------------------------
  store_e sstate_q;
  logic [MSW-1:0] msPre_q;
  logic [CTRL_HOLD_W-1:0] msHeld_q;
  logic [POS_W-1:0] storeNum_q;
  logic holdReached;

  assign holdReached = msHeld_q >= ctrl_q[CTRL_HOLD_LSB +: CTRL_HOLD_W];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      msPre_q <= '0;
      msHeld_q <= '0;
    end else if (clkEn) begin
      if (sstate_q != STO_HOLD || !sync_q.positionStoreRequest) begin
        msPre_q <= '0;
        msHeld_q <= '0;
      end else if (msPre_q == MS_LAST) begin
        msPre_q <= '0;
        if (!(&msHeld_q)) begin
          msHeld_q <= msHeld_q + 1'b1;
        end
      end else begin
        msPre_q <= msPre_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sstate_q <= STO_IDLE;
      storeNum_q <= '0;
    end else if (clkEn) begin
      case (sstate_q)
        STO_IDLE: begin
          if (pioEnable && rise.positionStoreRequest && teachMode) begin
            sstate_q <= STO_HOLD;
          end
        end
        STO_HOLD: begin
          if (!sync_q.positionStoreRequest || !teachMode) begin
            sstate_q <= STO_IDLE;
          end else if (holdReached) begin
            sstate_q <= STO_WAIT;
            storeNum_q <= sync_q.posSel;
          end
        end
        STO_WAIT: begin
          if (motionSts.nvWriteDone) begin
            sstate_q <= STO_DONE;
          end
        end
        STO_DONE: begin
          if (!sync_q.positionStoreRequest) begin
            sstate_q <= STO_IDLE;
          end
        end
        default: begin
          sstate_q <= STO_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Faults and status flags
  // ----------------------------------------------------------------------
  logic originFound_q;
  logic inPos_q;
  logic [POS_W-1:0] donePos_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarmActive_q <= 1'b0;
      estopActive_q <= 1'b0;
      originFound_q <= 1'b0;
    end else if (clkEn) begin
      if (motionSts.alarmEvent) begin
        alarmActive_q <= 1'b1;
      end else if (clearEdge) begin
        alarmActive_q <= 1'b0;
      end
      estopActive_q <= motionSts.estopActive;
      if (mstate_q == ST_HOME && motionSts.homeDone) begin
        originFound_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      donePos_q <= '0;
      inPos_q <= 1'b0;
    end else if (clkEn) begin
      if (startEdge) begin
        donePos_q <= '0;
        inPos_q <= 1'b0;
      end else if (mstate_q == ST_MOVE && motionSts.targetReached) begin
        donePos_q <= target_q;
        inPos_q <= motionSts.inBand;
      end else if (mstate_q == ST_MOVE && !canMove) begin
        inPos_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registered pins and motion commands
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pioOut <= '0;
      motionCmd <= '0;
    end else if (clkEn) begin
      pioOut.donePos <= donePos_q;
      pioOut.motionActive <= motionSts.moving;
      pioOut.teachStatusOut <= teachMode;
      pioOut.tableZoneOut <= zoneArmed_q && motionSts.inZone;
      pioOut.remoteAutoManuStatus <= sync_q.remoteAutoManuIn;
      pioOut.originFound <= originFound_q;
      pioOut.inPosition <= inPos_q;
      pioOut.storeDone <= sstate_q == STO_DONE;
      pioOut.operationReady <= canMove;
      pioOut.estopN <= !estopActive_q;
      pioOut.alarmN <= !alarmActive_q;
      motionCmd.servoOn <= sync_q.servoEnable;
      motionCmd.halt <= !sync_q.pauseN;
      motionCmd.moveGo <= startEdge && mstate_q == ST_IDLE;
      motionCmd.target <= sync_q.posSel;
      motionCmd.jogPlus <= jogPlusEdge && mstate_q == ST_IDLE;
      motionCmd.jogMinus <= jogMinusEdge && mstate_q == ST_IDLE;
      motionCmd.inching <= sync_q.stepStyleSelect;
      motionCmd.jogHold <= mstate_q == ST_JOG;
      motionCmd.homeGo <= homeEdge && mstate_q == ST_IDLE;
      motionCmd.storeGo <= sstate_q == STO_HOLD && holdReached
                           && sync_q.positionStoreRequest && teachMode;
      motionCmd.storeNum <= (sstate_q == STO_HOLD && holdReached)
                            ? sync_q.posSel : storeNum_q;
      motionCmd.alarmReset <= clearEdge;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  logic awHeld_q;
  logic wHeld_q;
  logic [AXI_ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic [31:0] readWord;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_q <= CTRL_RESET;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (awHeld_q && wHeld_q) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (decodeReg(awAddr_q) == REG_CTRL) begin
          s_axi_bresp <= RESP_OKAY;
          for (int b = 0; b < 4; b++) begin
            if (wStrb_q[b]) begin
              ctrl_q[8*b +: 8] <= wData_q[8*b +: 8];
            end
          end
        end else if (decodeReg(awAddr_q) == REG_NONE) begin
          s_axi_bresp <= RESP_DECERR;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    readWord = '0;
    if (decodeReg(s_axi_araddr) == REG_CTRL) begin
      readWord = ctrl_q;
    end else if (decodeReg(s_axi_araddr) == REG_STATUS) begin
      readWord[$bits(pio_out_s)-1:0] = pioOut;
    end else if (decodeReg(s_axi_araddr) == REG_INPUTS) begin
      readWord[IN_W-1:0] = sync_q;
    end else if (decodeReg(s_axi_araddr) == REG_POSITION) begin
      readWord[POS_W-1:0] = target_q;
      readWord[POS_DONE_LSB +: POS_W] = donePos_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readWord;
        s_axi_rresp <= (decodeReg(s_axi_araddr) == REG_NONE) ? RESP_DECERR
                                                             : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_alarm_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && motionSts.alarmEvent |=> alarmActive_q)
    else $error("alarm event lost");
  a_alarm_pin_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && motionSts.alarmEvent ##1 clkEn |=> !pioOut.alarmN)
    else $error("alarm pin not low after event");
  a_alarm_cleared: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && clearEdge && !motionSts.alarmEvent |=> !alarmActive_q)
    else $error("alarm not cleared by clear edge");
  a_start_clears_done: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    clkEn && startEdge ##1 clkEn |=> pioOut.donePos == '0)
    else $error("completed number not cleared by start");
  a_done_number: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && mstate_q == ST_MOVE && motionSts.targetReached && !startEdge
    |=> donePos_q == $past(target_q))
    else $error("completed number differs from target");
  a_origin_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    originFound_q |=> originFound_q)
    else $error("origin found dropped");
  a_store_hold_time: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    $rose(motionCmd.storeGo) |->
    $past(msHeld_q) >= $past(ctrl_q[CTRL_HOLD_LSB +: CTRL_HOLD_W]))
    else $error("store issued before hold time");
  a_input_sync: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && $past(clkEn) ##1 clkEn |=> sync_q == $past(pioIn, 2))
    else $error("input not passed through two stages");
  a_ready_faults: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clkEn && (alarmActive_q || !sync_q.servoEnable) |=> !pioOut.operationReady)
    else $error("ready asserted while unable to operate");
  a_zone_armed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !zoneArmed_q |=> !pioOut.tableZoneOut)
    else $error("zone output before any move command");

  c_move_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    mstate_q == ST_MOVE ##1 mstate_q == ST_IDLE && donePos_q != '0);
  c_store_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    sstate_q == STO_WAIT ##1 sstate_q == STO_DONE);
  c_home_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(originFound_q));
  c_alarm_clear: cover property (@(posedge sys_clk) disable iff (!rst_n)
    alarmActive_q ##1 !alarmActive_q);

endmodule : teaching_pio_handshake

// file: core/teaching_pio_pkg.sv
// Constants, field layouts and carriers of the teaching-pattern PIO block
package teaching_pio_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int STORE_HOLD_MS = 20;
  localparam int START_SETUP_MS = 6;
  localparam int POS_W = 6;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INPUTS = 8'h08;
  localparam logic [7:0] OFS_POSITION = 8'h0C;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HOLD_LSB = 8;
  localparam int CTRL_HOLD_W = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_1401;
  localparam int POS_DONE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum {REG_CTRL, REG_STATUS, REG_INPUTS, REG_POSITION, REG_NONE}
    reg_sel_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [POS_W-1:0] posSel;
    logic teachSelect;
    logic stepStyleSelect;
    logic jogPlusReq;
    logic jogMinusReq;
    logic remoteAutoManuIn;
    logic originSearchReq;
    logic pauseN;
    logic moveStart;
    logic positionStoreRequest;
    logic alarmClear;
    logic servoEnable;
  } pio_in_s;

  typedef struct packed {
    logic [POS_W-1:0] donePos;
    logic motionActive;
    logic teachStatusOut;
    logic tableZoneOut;
    logic remoteAutoManuStatus;
    logic originFound;
    logic inPosition;
    logic storeDone;
    logic operationReady;
    logic estopN;
    logic alarmN;
  } pio_out_s;

  typedef struct packed {
    logic servoOn;
    logic halt;
    logic moveGo;
    logic [POS_W-1:0] target;
    logic jogPlus;
    logic jogMinus;
    logic inching;
    logic jogHold;
    logic homeGo;
    logic storeGo;
    logic [POS_W-1:0] storeNum;
    logic alarmReset;
  } motion_cmd_s;

  typedef struct packed {
    logic moving;
    logic targetReached;
    logic inBand;
    logic inZone;
    logic homeDone;
    logic alarmEvent;
    logic estopActive;
    logic driveReady;
    logic nvWriteDone;
  } motion_sts_s;

endpackage : teaching_pio_pkg

// file: tb/motion_plant_model.sv
// Behavioural motion stage answering the block's motion commands
`timescale 1ns/100ps
module motion_plant_model import teaching_pio_pkg::*; #(
  parameter int LAT = 8
) (
  input wire logic sys_clk,
  input wire motion_cmd_s cmd,
  input wire logic fault,
  input wire logic estop,
  output motion_sts_s sts
);
  int cnt = 0;
  logic [2:0] job = 3'h0;
  logic [2:0] fin = 3'h0;
  logic go;
  assign go = cmd.moveGo | cmd.homeGo | cmd.storeGo | cmd.jogPlus
    | cmd.jogMinus;
  // Each move, jog, home or store command runs LAT cycles; move, home and store then give their completion pulse, jogs give none
  always @(posedge sys_clk) begin
    fin <= 3'h0;
    if (go) begin
      job <= {cmd.storeGo, cmd.homeGo, cmd.moveGo};
      cnt <= LAT;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      fin <= job;
    end
  end
  assign sts = '{moving: (cnt != 0 && !job[2]) || cmd.jogHold,
    targetReached: fin[0], inBand: cnt == 0, inZone: cnt < LAT / 2,
    homeDone: fin[1], alarmEvent: fault, estopActive: estop,
    driveReady: 1'b1, nvWriteDone: fin[2]};
endmodule : motion_plant_model

// file: tb/tb_teaching_pio_handshake.sv
// Self-checking bench of the teaching-pattern PIO handshake
`timescale 1ns/100ps
module tb_teaching_pio_handshake import teaching_pio_pkg::*;;
  localparam int MSC = 10;
  localparam int LAT = 8;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic fault = 1'b0;
  logic estop = 1'b0;
  logic clkEn = 1'b1;
  pio_in_s pioIn = '0;
  pio_out_s pioOut;
  motion_cmd_s mc;
  motion_sts_s ms;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] seed = 32'h33E0;
  logic [15:0] expQ[$];
  logic [5:0] p;
  int n_fail = 0, compares = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  teaching_pio_handshake #(.MS_TICK_CYCLES(MSC)) i_teaching_pio_handshake (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .pioIn(pioIn),
    .pioOut(pioOut), .motionCmd(mc), .motionSts(ms),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  motion_plant_model #(.LAT(LAT)) i_motion_plant_model (
    .sys_clk(sys_clk), .cmd(mc), .fault(fault), .estop(estop), .sts(ms));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [15:0] code(logic [5:0] k, logic i,
      logic [5:0] v);
    return {k, i, 3'h0, v};
  endfunction : code
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic axiWr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    logic ta, tw, tb;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    check("bresp", 32'(bresp), 32'(r));
  endtask : axiWr
  task automatic axiRd(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    logic ta, tr;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
      if (tr) check("rdata", rdata, d);
      if (tr) check("rresp", 32'(rresp), 32'(r));
    end while (!tr);
    rready <= 1'b0;
  endtask : axiRd
  // ----------------------------------------------------------------------
  // Monitor and timeout
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    logic [5:0] k;
    k = {mc.moveGo, mc.jogPlus, mc.jogMinus, mc.homeGo, mc.storeGo,
      mc.alarmReset};
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end else if (rst_n && k != 6'h00) begin
      check("pulse", code(k, mc.inching & (mc.jogPlus | mc.jogMinus),
        mc.moveGo ? mc.target : mc.storeGo ? mc.storeNum : 6'h00),
        expQ.size() ? expQ.pop_front() : 16'hFFFF);
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    wt(5);
    rst_n <= 1'b1;
    wt(6);
    check("alarmN", pioOut.alarmN, 1);
    check("estopN", pioOut.estopN, 1);
    check("homed", pioOut.originFound, 0);
    axiRd(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    axiRd(8'hF0, 32'h0, RESP_DECERR);
    axiWr(8'hF0, 32'h0, RESP_DECERR);
    for (int i = 0; i < 2; i++) begin
      pioIn.servoEnable <= i[0];
      pioIn.teachSelect <= i[0];
      pioIn.remoteAutoManuIn <= i[0];
      pioIn.pauseN <= i[0];
      wt(8);
      check("servo", mc.servoOn, i);
      check("ready", pioOut.operationReady, i);
      check("teach", pioOut.teachStatusOut, i);
      check("remote", pioOut.remoteAutoManuStatus, i);
      check("halt", mc.halt, !i[0]);
    end
    expQ.push_back(code(6'h04, 0, 0));
    pioIn.originSearchReq <= 1'b1;
    wt(LAT + 10);
    pioIn.originSearchReq <= 1'b0;
    check("homed", pioOut.originFound, 1);
    check("zone", pioOut.tableZoneOut, 0);
    for (int k = 0; k < 2; k++) begin
      p = 6'(rnd());
      pioIn.posSel <= p;
      wt(START_SETUP_MS * MSC);
      expQ.push_back(code(6'h20, 0, p));
      pioIn.moveStart <= 1'b1;
      wt(6);
      check("cleared", pioOut.donePos, 0);
      check("moving", pioOut.motionActive, 1);
      wt(LAT + 6);
      pioIn.moveStart <= 1'b0;
      check("donePos", pioOut.donePos, p);
      check("inPos", pioOut.inPosition, 1);
      check("moving", pioOut.motionActive, 0);
      check("zone", pioOut.tableZoneOut, 1);
    end
    for (int j = 0; j < 4; j++) begin
      pioIn.stepStyleSelect <= j[1];
      wt(4);
      expQ.push_back(code(j[0] ? 6'h08 : 6'h10, j[1], 0));
      pioIn.jogPlusReq <= !j[0];
      pioIn.jogMinusReq <= j[0];
      wt(8);
      pioIn.jogPlusReq <= 1'b0;
      pioIn.jogMinusReq <= 1'b0;
      wt(LAT + 8);
    end
    pioIn.positionStoreRequest <= 1'b1;
    wt(10 * MSC);
    pioIn.positionStoreRequest <= 1'b0;
    wt(8);
    p = 6'(rnd());
    pioIn.posSel <= p;
    wt(START_SETUP_MS * MSC);
    expQ.push_back(code(6'h02, 0, p));
    pioIn.positionStoreRequest <= 1'b1;
    wt(STORE_HOLD_MS * MSC + LAT + 10);
    check("stored", pioOut.storeDone, 1);
    pioIn.positionStoreRequest <= 1'b0;
    fault <= 1'b1;
    wt(4);
    fault <= 1'b0;
    wt(4);
    check("alarmN", pioOut.alarmN, 0);
    check("ready", pioOut.operationReady, 0);
    expQ.push_back(code(6'h01, 0, 0));
    pioIn.alarmClear <= 1'b1;
    wt(8);
    pioIn.alarmClear <= 1'b0;
    check("alarmN", pioOut.alarmN, 1);
    estop <= 1'b1;
    wt(4);
    check("estopN", pioOut.estopN, 0);
    estop <= 1'b0;
    axiWr(OFS_CTRL, 32'h0000_1400, RESP_OKAY);
    pioIn.moveStart <= 1'b1;
    wt(10);
    pioIn.moveStart <= 1'b0;
    axiWr(OFS_CTRL, CTRL_RESET, RESP_OKAY);
    clkEn <= 1'b0;
    pioIn.teachSelect <= 1'b0;
    wt(8);
    check("frozen", pioOut.teachStatusOut, 1);
    pioIn.teachSelect <= 1'b1;
    clkEn <= 1'b1;
    wt(10);
    check("queue", expQ.size(), 0);
    stop_test();
  end
endmodule : tb_teaching_pio_handshake
